// ### hw/hbd_pkg.sv
package hbd_pkg;

    // Clock and host wait timing
    localparam int CLK_MHZ = 10;
    localparam int WAIT_NS = 300;
    localparam logic [3:0] WAIT_CYC = 4'((WAIT_NS * CLK_MHZ + 999) / 1000);

    // Strap capture settles once the pin synchroniser is full
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int STRAP_CHANNEL_BIT = 2;

    // Width of the synchronised pin vector
    localparam int SYNC_W = 69;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MISC = 8'h04;
    localparam logic [7:0] REG_HOSTDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Field positions
    localparam int CTRL_FORCE_BLANK_BIT = 0;
    localparam int CTRL_WIDE_IO_BIT = 1;
    localparam int MISC_CLKSEL_LO = 2;
    localparam int MONITOR_SENSE_BIT = 4;
    localparam int STATUS_SENSE_BIT = 16;
    localparam int STATUS_CHANNEL_BIT = 17;
    localparam int STATUS_ACTIVE_BIT = 18;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [15:0] HOSTDATA_RST = 16'h0000;

    // Host I/O ports
    localparam logic [15:0] PORT_MISC = 16'h03c2;
    localparam logic [15:0] PORT_PAL_MASK = 16'h03c6;
    localparam logic [15:0] PORT_PAL_RADDR = 16'h03c7;
    localparam logic [15:0] PORT_PAL_DATA = 16'h03c9;

    // Host memory windows
    localparam logic [23:0] ROM_LO = 24'h0c0000;
    localparam logic [23:0] ROM_HI = 24'h0dffff;
    localparam logic [23:0] VRAM_LO = 24'h0a0000;
    localparam logic [23:0] VRAM_HI = 24'h0bffff;

    // Host cycle tracking
    typedef enum logic [0:0] {CYC_IDLE, CYC_ACTIVE} hbd_cyc_e;

endpackage

// ### hw/hbd_sync.sv
`timescale 1ns/1ns
module hbd_sync import hbd_pkg::*; #(
    parameter int W = SYNC_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hbd_sync_s;

    hbd_sync_s q_r;
    hbd_sync_s q_nxt;

    // The first stage feeds only the second stage
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.meta = din;
        q_nxt.stable = q_r.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    assign dout = q_r.stable;

endmodule

// ### hw/hbd_pixclk.sv
`timescale 1ns/1ns
module hbd_pixclk import hbd_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised video clocks and selection
    input wire logic [2:0] vclk_s,
    input wire logic [1:0] sel,
    // Selected pixel clock
    output logic clk_out
);

    typedef struct packed {
        logic pix;
    } hbd_pixclk_s;

    hbd_pixclk_s q_r;
    hbd_pixclk_s q_nxt;

    // Sampled source only follows video clocks well below the system clock rate
    always_comb
    begin
        q_nxt = q_r;
        case (sel)
            2'h1: q_nxt.pix = vclk_s[1];
            2'h2: q_nxt.pix = vclk_s[2];
            default: q_nxt.pix = vclk_s[0];
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    assign clk_out = q_r.pix;

endmodule

// ### hw/hbd_host_dac_port.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module hbd_host_dac_port import hbd_pkg::*; (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host bus pins
    input wire logic [23:0] host_addr,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic [1:0] host_data_oe,
    input wire logic upper_byte_select_n,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic io_decode_enable_n,
    input wire logic slot_setup_select_n,
    output logic io_wide_ack_n,
    output logic io_wide_ack_oe,
    output logic ready_out,
    output logic ready_oe,
    output logic buffer_dir,
    output logic upper_buffer_enable_n,
    output logic lower_buffer_enable_n,
    output logic rom_wide_select_n,
    // Strap pins
    input wire logic [15:0] vram_data,
    // Video and DAC pins
    input wire logic video_clock_in_0,
    input wire logic video_clock_in_1,
    input wire logic video_clock_in_2,
    input wire logic ext_pixel_data_override_n,
    input wire logic ext_pixel_clock_override_n,
    input wire logic monitor_sense,
    output logic [7:0] pixel_data_out,
    output logic pixel_data_oe,
    output logic pixel_clock_out,
    output logic pixel_clock_oe,
    output logic blanking_n,
    output logic palette_read_strobe_n,
    output logic palette_write_strobe_n,
    // Display pipeline, same clock
    input wire logic [7:0] pixel_stream_in,
    input wire logic pixel_blank_n_in
);

    typedef struct packed {
        hbd_cyc_e cyc;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic [15:0] strap_config;
        logic cmd_n_prev;
        logic is_mem;
        logic is_rd;
        logic [23:0] addr;
        logic bhe_n;
        logic [15:0] wdata;
        logic [1:0] ctrl;
        logic [7:0] misc;
        logic [15:0] hostdata;
        logic [3:0] wait_cnt;
        logic dir;
        logic ubuf_n;
        logic lbuf_n;
        logic rom_n;
        logic iow_oe;
        logic prd_n;
        logic pwr_n;
        logic rdy;
        logic rdy_oe;
        logic [15:0] dout;
        logic [1:0] doe;
        logic [7:0] pix;
        logic pix_oe;
        logic pclk_oe;
        logic blank_n;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } hbd_state_s;

    hbd_state_s q_r;
    hbd_state_s q_nxt;

    logic [SYNC_W-1:0] pins_s;
    logic s_mrd_n, s_mwr_n, s_ior_n, s_iow_n, s_bhe_n, s_io_decode_enable_n_n, s_slot_n;
    logic s_exvid_n, s_expclk_n, s_sense;
    logic [23:0] s_addr;
    logic [15:0] s_data, s_vram;
    logic [2:0] s_vclk;
    logic chan_mode, act;
    logic isa_mem_rd, isa_mem_wr, isa_io_rd, isa_io_wr, isa_strobe;
    logic cmd_low, ch_rd, ch_wr, ch_start;
    logic start_c, end_c, st_mem, st_rd;
    logic port_misc, port_pal, pal_rd_port, in_vram, in_rom, claimed;
    logic wide16, hi_lane, lo_lane;
    logic own_rd_c, drive_c, pal_rd_c, pal_wr_c, own_mem_c, rom_c, card_fb_c;
    logic apb_acc;

    // Every pin passes two flops; address and data settle before the strobe seen behind them
    hbd_sync #(.W(SYNC_W)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din({mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n,
              upper_byte_select_n, io_decode_enable_n, slot_setup_select_n,
              ext_pixel_data_override_n, ext_pixel_clock_override_n, monitor_sense,
              host_addr, host_data_in, vram_data,
              video_clock_in_2, video_clock_in_1, video_clock_in_0}),
        .dout(pins_s)
    );

    // Slices of the synchronised pin vector
    assign {s_mrd_n, s_mwr_n, s_ior_n, s_iow_n, s_bhe_n, s_io_decode_enable_n_n, s_slot_n} = pins_s[68:62];
    assign {s_exvid_n, s_expclk_n, s_sense} = pins_s[61:59];
    assign s_addr = pins_s[58:35];
    assign s_data = pins_s[34:19];
    assign s_vram = pins_s[18:3];
    assign s_vclk = pins_s[2:0];

    // Pixel clock source follows the misc output clock select field
    hbd_pixclk u_pixclk (
        .clk(pclk),
        .rst_n(presetn),
        .vclk_s(s_vclk),
        .sel(q_r.misc[MISC_CLKSEL_LO +: 2]),
        .clk_out(pixel_clock_out)
    );

    // Bus personality and strobe mode decode
    assign chan_mode = q_r.strap_config[STRAP_CHANNEL_BIT];
    assign isa_mem_rd = !s_mrd_n;
    assign isa_mem_wr = !s_mwr_n;
    assign isa_io_rd = !s_ior_n && !s_io_decode_enable_n_n;
    assign isa_io_wr = !s_iow_n && !s_io_decode_enable_n_n;
    assign isa_strobe = isa_mem_rd || isa_mem_wr || isa_io_rd || isa_io_wr;

    // Channel mode: status lines low for the command type, command strobe frames the cycle
    assign cmd_low = !s_iow_n;
    assign ch_rd = !s_ior_n && s_mwr_n;
    assign ch_wr = !s_mwr_n && s_ior_n;
    assign ch_start = cmd_low && q_r.cmd_n_prev && (ch_rd || ch_wr);

    // Cycle start and end; nothing is decoded before the straps are in
    assign act = (q_r.cyc == CYC_ACTIVE);
    assign start_c = q_r.strap_done && !act && (chan_mode ? ch_start : isa_strobe);
    assign end_c = act && (chan_mode ? !cmd_low : !isa_strobe);
    assign st_mem = chan_mode ? s_mrd_n : (isa_mem_rd || isa_mem_wr);
    assign st_rd = chan_mode ? ch_rd : (isa_mem_rd || isa_io_rd);

    // Address decode on the latched cycle
    assign port_misc = !q_r.is_mem && (q_r.addr[15:0] == PORT_MISC);
    assign port_pal = !q_r.is_mem && (q_r.addr[15:0] >= PORT_PAL_MASK) && (q_r.addr[15:0] <= PORT_PAL_DATA);
    assign pal_rd_port = port_pal && (q_r.addr[15:0] != PORT_PAL_RADDR);
    assign in_vram = q_r.is_mem && (q_r.addr >= VRAM_LO) && (q_r.addr <= VRAM_HI);
    assign in_rom = q_r.is_mem && (q_r.addr >= ROM_LO) && (q_r.addr <= ROM_HI);
    assign claimed = port_misc || port_pal || in_vram;

    // Byte lanes: odd 8-bit cycles use the low lane, odd high-byte cycles the high lane
    assign wide16 = !q_r.addr[0] && !q_r.bhe_n;
    assign hi_lane = !q_r.bhe_n;
    assign lo_lane = !(q_r.addr[0] && !q_r.bhe_n);

    // Qualified cycle terms
    assign own_rd_c = act && q_r.is_rd && claimed;
    assign drive_c = act && q_r.is_rd && (in_vram || port_misc);
    assign pal_rd_c = act && q_r.is_rd && pal_rd_port;
    assign pal_wr_c = act && !q_r.is_rd && port_pal;
    assign own_mem_c = act && in_vram;
    assign rom_c = act && in_rom;
    assign card_fb_c = act && claimed && s_slot_n;
    assign apb_acc = psel && penable;

    // Next state of everything
    always_comb
    begin
        logic [15:0] rd_word;
        rd_word = 16'h0000;
        q_nxt = q_r;
        q_nxt.cmd_n_prev = !cmd_low;

        // Straps are taken once the synchroniser holds post-reset pin levels
        if (!q_r.strap_done)
        begin
            if (q_r.strap_cnt == STRAP_SETTLE)
            begin
                q_nxt.strap_config = s_vram;
                q_nxt.strap_done = 1'b1;
            end
            else
                q_nxt.strap_cnt = q_r.strap_cnt + 2'h1;
        end

        // Host cycle tracking
        case (q_r.cyc)
            CYC_IDLE:
            begin
                if (start_c)
                begin
                    q_nxt.cyc = CYC_ACTIVE;
                    q_nxt.is_mem = st_mem;
                    q_nxt.is_rd = st_rd;
                    q_nxt.addr = s_addr;
                    q_nxt.bhe_n = s_bhe_n;
                    q_nxt.wait_cnt = WAIT_CYC;
                end
            end
            CYC_ACTIVE:
            begin
                q_nxt.wdata = s_data;
                if (q_r.wait_cnt != 4'h0)
                    q_nxt.wait_cnt = q_r.wait_cnt - 4'h1;
                if (end_c)
                begin
                    q_nxt.cyc = CYC_IDLE;
                    if (!q_r.is_rd && port_misc)
                        q_nxt.misc = q_r.wdata[7:0];
                end
            end
            default: q_nxt.cyc = CYC_IDLE;
        endcase

        // Host read data: video window from the host data register, port 3C2 shows the sense pin
        rd_word[MONITOR_SENSE_BIT] = s_sense;
        if (in_vram)
            rd_word = q_r.hostdata;
        if (q_r.addr[0] && q_r.bhe_n)
            q_nxt.dout = {8'h00, rd_word[15:8]};
        else
            q_nxt.dout = rd_word;
        q_nxt.doe = drive_c ? {hi_lane, lo_lane} : 2'h0;

        // Buffer steering
        q_nxt.dir = own_rd_c;
        q_nxt.ubuf_n = !(act && claimed && hi_lane);
        q_nxt.lbuf_n = !(act && claimed && lo_lane);

        // Dual-function pins follow the personality
        q_nxt.rom_n = chan_mode ? !card_fb_c : !rom_c;
        q_nxt.iow_oe = !chan_mode && act && !q_r.is_mem && claimed && q_r.ctrl[CTRL_WIDE_IO_BIT];

        // Palette strobes
        q_nxt.prd_n = !pal_rd_c;
        q_nxt.pwr_n = !pal_wr_c;

        // Ready is driven only for video memory, low until the wait count runs out
        q_nxt.rdy_oe = own_mem_c;
        q_nxt.rdy = (q_r.wait_cnt == 4'h0);

        // DAC side
        q_nxt.pix = pixel_stream_in;
        q_nxt.pix_oe = s_exvid_n;
        q_nxt.pclk_oe = s_expclk_n;
        q_nxt.blank_n = pixel_blank_n_in && !q_r.ctrl[CTRL_FORCE_BLANK_BIT];

        // APB: one wait state, read data set with pready
        q_nxt.pready = apb_acc && !q_r.pready;
        if (apb_acc && !q_r.pready)
        begin
            q_nxt.prdata = 32'h00000000;
            q_nxt.pslverr = 1'b0;
            case (paddr)
                REG_CTRL: q_nxt.prdata[1:0] = q_r.ctrl;
                REG_MISC: q_nxt.prdata[7:0] = q_r.misc;
                REG_HOSTDATA: q_nxt.prdata[15:0] = q_r.hostdata;
                REG_STATUS:
                begin
                    q_nxt.prdata[15:0] = q_r.strap_config;
                    q_nxt.prdata[STATUS_SENSE_BIT] = s_sense;
                    q_nxt.prdata[STATUS_CHANNEL_BIT] = chan_mode;
                    q_nxt.prdata[STATUS_ACTIVE_BIT] = act;
                end
                default: q_nxt.pslverr = 1'b1;
            endcase
        end

        // APB writes land on the completing edge; a software misc write beats a host one
        if (apb_acc && q_r.pready && pwrite)
        begin
            case (paddr)
                REG_CTRL: q_nxt.ctrl = pwdata[1:0];
                REG_MISC: q_nxt.misc = pwdata[7:0];
                REG_HOSTDATA: q_nxt.hostdata = pwdata[15:0];
                default: q_nxt.hostdata = q_r.hostdata;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_r <= '0;
            q_r.cyc <= CYC_IDLE;
            q_r.cmd_n_prev <= 1'b1;
            q_r.ctrl <= CTRL_RST;
            q_r.misc <= MISC_RST;
            q_r.hostdata <= HOSTDATA_RST;
            q_r.ubuf_n <= 1'b1;
            q_r.lbuf_n <= 1'b1;
            q_r.rom_n <= 1'b1;
            q_r.prd_n <= 1'b1;
            q_r.pwr_n <= 1'b1;
            q_r.blank_n <= 1'b0;
        end
        else
            q_r <= q_nxt;
    end

    // Outputs straight from the state register, except the wide ack pin, which is tied low
    assign prdata = q_r.prdata;
    assign pready = q_r.pready;
    assign pslverr = q_r.pslverr;
    assign host_data_out = q_r.dout;
    assign host_data_oe = q_r.doe;
    assign io_wide_ack_n = 1'b0; // Pin only ever pulls low; the enable does the signalling
    assign io_wide_ack_oe = q_r.iow_oe;
    assign ready_out = q_r.rdy;
    assign ready_oe = q_r.rdy_oe;
    assign buffer_dir = q_r.dir;
    assign upper_buffer_enable_n = q_r.ubuf_n;
    assign lower_buffer_enable_n = q_r.lbuf_n;
    assign rom_wide_select_n = q_r.rom_n;
    assign pixel_data_out = q_r.pix;
    assign pixel_data_oe = q_r.pix_oe;
    assign pixel_clock_oe = q_r.pclk_oe;
    assign blanking_n = q_r.blank_n;
    assign palette_read_strobe_n = q_r.prd_n;
    assign palette_write_strobe_n = q_r.pwr_n;

    // Checks
    chk_dir_own_read: assert property (@(posedge pclk) disable iff (!presetn)
        buffer_dir |-> $past(own_rd_c)) else $error("direction high outside own read");
    chk_pal_read_ports: assert property (@(posedge pclk) disable iff (!presetn)
        pal_rd_c |=> !palette_read_strobe_n) else $error("palette read strobe missed");
    chk_pal_read_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !palette_read_strobe_n |-> $past(act && q_r.is_rd && !q_r.is_mem)) else $error("stray palette read");
    chk_pal_write_ports: assert property (@(posedge pclk) disable iff (!presetn)
        !palette_write_strobe_n |-> $past(pal_wr_c)) else $error("stray palette write");
    chk_ready_mem_only: assert property (@(posedge pclk) disable iff (!presetn)
        ready_oe |-> $past(own_mem_c)) else $error("ready driven outside video memory");
    chk_ready_wait_end: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ready_oe) |-> !ready_out ##[1:4] (ready_out || !ready_oe)) else $error("ready never released");
    chk_data_own_read: assert property (@(posedge pclk) disable iff (!presetn)
        (host_data_oe != 2'h0) |-> $past(drive_c)) else $error("data driven on foreign cycle");
    chk_wide_both_lanes: assert property (@(posedge pclk) disable iff (!presetn)
        (host_data_oe == 2'h3) |-> $past(wide16)) else $error("both lanes on narrow cycle");
    chk_rom_window_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (!chan_mode && !rom_wide_select_n) |-> $past(rom_c)) else $error("rom select outside window");
    chk_pix_override: assert property (@(posedge pclk) disable iff (!presetn)
        !s_exvid_n |=> !pixel_data_oe) else $error("pixel data driven under override");
    chk_mode_stable: assert property (@(posedge pclk) disable iff (!presetn)
        q_r.strap_done |=> $stable(q_r.strap_config)) else $error("strap changed after capture");

endmodule

// ### testbench/hbd_host_model.sv
`timescale 1ns/1ns
// Host master: one low strobe per cycle type in strobe mode, or a raw channel pattern, idle high
module hbd_host_model (
    // Clock
    input wire logic clk,
    // Host pins
    output logic [23:0] addr,
    output logic bhe_n,
    output logic [3:0] strobe_n,
    output logic io_en_n
);
    // Idle levels at time zero
    initial
    begin
        addr = 24'hffffff;
        bhe_n = 1'b1;
        strobe_n = 4'hf;
        io_en_n = 1'b1;
    end
    // Strobe k: 0 mem read, 1 mem write, 2 io read, 3 io write
    task automatic start(input int k, input logic [23:0] a, input logic b, input logic e);
        @(posedge clk);
        addr <= a;
        bhe_n <= b;
        io_en_n <= e;
        strobe_n <= ~(4'h1 << k);
    endtask
    // Channel cycle: bit 0 memory qualifier, bits 1 and 2 status, bit 3 command, all set together
    task automatic chan(input logic [3:0] s, input logic [23:0] a, input logic b);
        @(posedge clk);
        addr <= a;
        bhe_n <= b;
        strobe_n <= s;
    endtask
    // Address is scrambled on release so a stale latch never looks right
    task automatic stop();
        @(posedge clk);
        strobe_n <= 4'hf;
        addr <= ~addr;
        io_en_n <= 1'b1;
    endtask
endmodule

// ### testbench/tb_hbd_host_dac_port.sv
`timescale 1ns/1ns
// Strobe then channel personality bench: host cycles, APB registers and DAC side
module tb_hbd_host_dac_port import hbd_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00, pix_in = 8'h00, pix_out;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h4341;
    logic [23:0] haddr;
    logic [15:0] hdin = 16'h0, hdout, straps = 16'h0, hd, hd16;
    logic [1:0] hoe, ln;
    logic [3:0] stb_n;
    logic [2:0] vclk = 3'h0;
    logic bhe_n, ioen_n, dir, ube_n, lbe_n, rom_n, rdy, rdy_oe, pd_oe, pc_out, pc_oe, blank_n, prd_n, pwr_n;
    logic pd_ovr_n = 1, pc_ovr_n = 1, sense = 1, own, rom;
    logic wack_n, wack_oe, slot_n = 1, pblank_n = 1;
    int bad_count = 0, compares = 0, cyc_n = 0;
    // Clock and hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    hbd_host_model i_hbd_host_model (.clk(pclk), .addr(haddr), .bhe_n(bhe_n), .strobe_n(stb_n), .io_en_n(ioen_n));
    hbd_host_dac_port i_hbd_host_dac_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_addr(haddr), .host_data_in(hdin), .host_data_out(hdout), .host_data_oe(hoe),
        .upper_byte_select_n(bhe_n), .mem_read_strobe_n(stb_n[0]), .mem_write_strobe_n(stb_n[1]),
        .io_read_strobe_n(stb_n[2]), .io_write_strobe_n(stb_n[3]), .io_decode_enable_n(ioen_n),
        .slot_setup_select_n(slot_n), .io_wide_ack_n(wack_n), .io_wide_ack_oe(wack_oe),
        .ready_out(rdy), .ready_oe(rdy_oe),
        .buffer_dir(dir), .upper_buffer_enable_n(ube_n), .lower_buffer_enable_n(lbe_n), .rom_wide_select_n(rom_n),
        .vram_data(straps), .video_clock_in_0(vclk[0]), .video_clock_in_1(vclk[1]), .video_clock_in_2(vclk[2]),
        .ext_pixel_data_override_n(pd_ovr_n), .ext_pixel_clock_override_n(pc_ovr_n), .monitor_sense(sense),
        .pixel_data_out(pix_out), .pixel_data_oe(pd_oe), .pixel_clock_out(pc_out), .pixel_clock_oe(pc_oe),
        .blanking_n(blank_n), .palette_read_strobe_n(prd_n), .palette_write_strobe_n(pwr_n),
        .pixel_stream_in(pix_in), .pixel_blank_n_in(pblank_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask
    // APB transfer; the request holds until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Host cycle: sample well after the strobe, then check the rest state
    task automatic hbeg(input int k, input logic [23:0] a, input logic b, input logic e);
        i_hbd_host_model.start(k, a, b, e);
        repeat (8) @(posedge pclk);
    endtask
    task automatic hend();
        i_hbd_host_model.stop();
        repeat (7) @(posedge pclk);
        chk({dir, hoe, ube_n, lbe_n, prd_n, pwr_n}, 7'h0f, "rest");
    endtask
    // Channel cycle, upper byte select low; exp is {dir, pal rd, pal wr, rom/feedback, ready oe, wide ack oe}
    task automatic ccyc(input logic [3:0] s, input logic [23:0] a, input logic [5:0] exp);
        i_hbd_host_model.chan(s, a, 1'b0);
        repeat (8) @(posedge pclk);
        chk({dir, prd_n, pwr_n, rom_n, rdy_oe, wack_oe}, exp, "channel cycle");
        hend();
    endtask
    task automatic conclude();
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        rd = rnd();
        straps = rd[15:0] & 16'hfffb;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[17:0], {1'b0, sense, straps}, "status");
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1, "unmapped");
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        chk(blank_n, 1'b0, "blank");
        apb(1'b1, REG_CTRL, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            rd = rnd();
            vclk <= rd[2:0];
            apb(1'b1, REG_MISC, s << MISC_CLKSEL_LO);
            repeat (8) @(posedge pclk);
            chk(pc_out, vclk[(s == 3) ? 0 : s], "pixel clock");
        end
        repeat (4)
        begin
            rd = rnd();
            pix_in <= rd[7:0];
            pd_ovr_n <= rd[8];
            pc_ovr_n <= rd[9];
            pblank_n <= rd[10];
            repeat (5) @(posedge pclk);
            chk(pix_out, pix_in, "pixel data");
            chk(blank_n, pblank_n, "blank follow");
            chk({pd_oe, pc_oe}, {pd_ovr_n, pc_ovr_n}, "override");
        end
        rd = rnd();
        hd = rd[15:0];
        apb(1'b1, REG_HOSTDATA, {16'h0, hd});
        for (int p = 'h3c5; p < 'h3cb; p++)
            for (int k = 2; k < 4; k++)
                for (int e = 0; e < 2; e++)
                begin
                    hbeg(k, p, 1'b1, e);
                    chk(prd_n, !(e == 0 && k == 2 && p != 'h3c7 && p > 'h3c5 && p < 'h3ca), "pal rd");
                    chk(pwr_n, !(e == 0 && k == 3 && p > 'h3c5 && p < 'h3ca), "pal wr");
                    hend();
                end
        // Sense read at both levels, with the wide I/O acknowledge enabled
        apb(1'b1, REG_CTRL, 32'h2);
        repeat (2)
        begin
            sense <= ~sense;
            hbeg(2, PORT_MISC, 1'b1, 1'b0);
            chk({dir, ube_n, lbe_n, hoe, hdout[4]}, {3'b110, 2'b01, sense}, "sense");
            chk({wack_oe, wack_n}, 2'b10, "wide io ack");
            hend();
        end
        // Upper byte select walks all four lane pairings inside the video window
        for (int i = 0; i < 8; i++)
        begin
            rd = rnd();
            rd[23:0] = (i < 4) ? 24'h0a0000 + i * 24'h7fff : 24'h0bffff + (i - 3) * 24'h10000;
            own = rd[23:0] <= VRAM_HI;
            rom = rd[23:0] >= ROM_LO && rd[23:0] <= ROM_HI;
            ln = own ? {!i[1], rd[0] ? i[1] : 1'b1} : 2'b00;
            hd16 = (rd[0] && i[1]) ? {8'h00, hd[15:8]} : hd;
            hbeg(0, rd[23:0], i[1], 1'b1);
            chk(rom_n, !rom, "rom");
            chk({rdy_oe, own ? rdy : 1'b0, wack_oe}, {own, own, 1'b0}, "ready");
            chk(hoe, ln, "lanes");
            if (own)
                chk(hdout & {{8{ln[1]}}, {8{ln[0]}}}, hd16 & {{8{ln[1]}}, {8{ln[0]}}}, "vram data");
            hend();
        end
        rd = rnd();
        hdin <= rd[15:0];
        hbeg(3, PORT_MISC, 1'b1, 1'b0);
        hend();
        apb(1'b0, REG_MISC, 32'h0);
        chk(rd, {24'h0, hdin[7:0]}, "host misc");
        // Second reset with the channel personality strapped
        presetn <= 1'b0;
        straps <= straps | 16'h0004;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[17:0], {1'b1, sense, straps}, "channel straps");
        ccyc(4'b0010, 24'h0003c8, 6'b101000);
        ccyc(4'b0100, 24'h0003c6, 6'b010000);
        ccyc(4'b0011, 24'h0a0000, 6'b111010);
        ccyc(4'b0011, 24'h0c0000, 6'b011100);
        ccyc(4'b0010, 24'h0a0000, 6'b011100);
        ccyc(4'b0000, 24'h0003c8, 6'b011100);
        slot_n <= 1'b0;
        ccyc(4'b0010, 24'h0003c8, 6'b101100);
        conclude();
    end
endmodule
